// ==== src/ccu_top.sv ====
// Capture/compare/PWM control unit with APB register access.
// Assumes timer one count and its tick enable come from outside, and the
// PWM timebase supplies the modulated and dead-band complement signals.
//
// Contract
// R1 - Modes 4..7 capture on chosen edges
// R2 - Mode 0 resets unit; 1,3 do nothing
// R3 - Modes 2,8,9 toggle/set/clear, set flag
// R4 - Mode 10 only sets flag, pin free
// R5 - Mode 11 flag, timer reset, conversion start
// R6 - Modes 12..15 PWM with pair polarities
// R7 - Steering selects single, half, full bridges
// R8 - Steering ignored outside PWM modes
// R9 - Control bits 5:4 are duty low bits
// R10 - Capture copies 16-bit timer count
// R11 - Capture sets flag; software clears it
// R12 - New capture overwrites unread value
// R13 - Edge detector watches pin even driven
// R14 - Timer one must run synchronously
// R15 - Prescaler cleared when off or not capturing
// R16 - Prescale change keeps prescaler count
// R17 - Mode change may cause false capture
// R18 - Compare 16-bit value against timer count
// R19 - Zero control clears latch, frees pin
// R20 - Trigger now, timer reset next tick
// R21 - Trigger reset leaves overflow flag alone
// R22 - Vanished match cancels pending timer reset
// R23 - Pin synchronised before edge detection
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module ccu_top
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Timer one and converter
	input wire logic [15:0] timer_one_count_in,
	input wire logic timer_one_tick_in,
	output logic timer_one_reset_out,
	output logic adc_start_out,
	// PWM timebase
	input wire logic pwm_mod_in,
	input wire logic pwm_comp_in,
	output logic [9:0] duty_value_out,
	// Pins
	input wire logic unit_pin_in,
	output logic pwm_out_a_out,
	output logic pwm_out_b_out,
	output logic pwm_out_c_out,
	output logic pwm_out_d_out,
	output logic [3:0] pin_own_out
);
	import ccu_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] ctrl_reg; // Control register
	logic [7:0] vlow_reg; // Value low byte
	logic [7:0] vhigh_reg; // Value high byte
	logic flag_reg; // Unit event flag
	logic enable_reg; // Unit event enable, stored for software
	logic latch_reg; // Compare output latch
	logic [3:0] pre_reg; // Capture prescaler count
	logic sync1_reg; // Pin synchroniser first stage
	logic sync2_reg; // Pin synchroniser second stage
	logic sync3_reg; // Previous synchronised level
	logic match_prev_reg; // Match seen last cycle
	logic pend_reg; // Timer reset waiting for tick
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;

	// Decoded fields
	logic [3:0] mode;
	logic [1:0] steer;
	ccu_class_t cls;
	logic wr_en;
	logic rise;
	logic fall;
	logic cap_evt;
	logic match;
	logic match_evt;
	logic cmp_evt;

	// Classify a mode code into its operating class
	function automatic ccu_class_t mode_class(input logic [3:0] m);
		ccu_class_t c;
		c = CCU_OFF;
		// Reserved codes fall through to off
		case (m)
			CCU_M_CAP_FALL, CCU_M_CAP_RISE, CCU_M_CAP_4, CCU_M_CAP_16:
				c = CCU_CAPTURE;
			CCU_M_TOGGLE, CCU_M_SET, CCU_M_CLEAR, CCU_M_SOFT,
			CCU_M_SPECIAL:
				c = CCU_COMPARE;
			default:
				c = (m[3:2] == CCU_M_PWM_TOP) ? CCU_PWM : CCU_OFF;
		endcase
		return c;
	endfunction

	// Decode of a word-aligned register address
	function automatic logic addr_hit(input logic [7:0] a);
		return (a == CCU_CTRL_OFS) || (a == CCU_VLOW_OFS) ||
			(a == CCU_VHIGH_OFS) || (a == CCU_FLAG_OFS);
	endfunction

	assign mode = ctrl_reg[CCU_MODE_MSB:CCU_MODE_LSB];
	assign steer = ctrl_reg[CCU_STEER_MSB:CCU_STEER_LSB];
	// R2 reserved codes
	assign cls = mode_class(mode);
	assign wr_en = psel_in & penable_in & pready_reg & pwrite_in;

	// ==========================================================
	// APB slave: no wait states, answer in the access phase
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= psel_in & ~penable_in;
			pslverr_reg <= psel_in & ~penable_in & ~addr_hit(paddr_in);
			prdata_reg <= 32'h0000_0000;
			// Read data prepared in the setup phase
			if (psel_in && !penable_in && !pwrite_in)
			begin
				case (paddr_in)
					CCU_CTRL_OFS: prdata_reg[7:0] <= ctrl_reg;
					CCU_VLOW_OFS: prdata_reg[7:0] <= vlow_reg;
					CCU_VHIGH_OFS: prdata_reg[7:0] <= vhigh_reg;
					CCU_FLAG_OFS:
					begin
						prdata_reg[CCU_FLAG_BIT] <= flag_reg;
						prdata_reg[CCU_ENABLE_BIT] <= enable_reg;
						prdata_reg[CCU_PIN_BIT] <= sync2_reg;
						prdata_reg[CCU_LATCH_BIT] <= latch_reg;
					end
					default: prdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;

	// ==========================================================
	// Control register and event enable
	// R17 enable held for software
	// The unit never gates events with it, so a false capture on a
	// mode change still sets the flag; software masks and clears it
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ctrl_reg <= CCU_CTRL_RST;
			enable_reg <= 1'b0;
		end
		else if (wr_en)
		begin
			if (paddr_in == CCU_CTRL_OFS)
				ctrl_reg <= pwdata_in[7:0];
			if (paddr_in == CCU_FLAG_OFS)
				enable_reg <= pwdata_in[CCU_ENABLE_BIT];
		end
	end

	// ==========================================================
	// Pin synchroniser and edge detection
	// R23 two stages, edges read only from stage two onward
	// R13 the pin level is sampled whatever drives it
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= unit_pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	assign rise = sync2_reg & ~sync3_reg;
	assign fall = ~sync2_reg & sync3_reg;

	// ==========================================================
	// Capture prescaler
	// R15 cleared when off or outside capture
	// R16 no clear when moving between capture settings
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			pre_reg <= 4'h0;
		else if (cls != CCU_CAPTURE)
			pre_reg <= 4'h0;
		else if (rise)
			pre_reg <= pre_reg + 4'h1;
	end

	// R1 capture event selection
	always_comb
	begin
		cap_evt = 1'b0;
		case (mode)
			CCU_M_CAP_FALL: cap_evt = fall;
			CCU_M_CAP_RISE: cap_evt = rise;
			CCU_M_CAP_4: cap_evt = rise &&
				(pre_reg[1:0] == CCU_PRE_LAST4[1:0]);
			CCU_M_CAP_16: cap_evt = rise && (pre_reg == CCU_PRE_LAST16);
			default: cap_evt = 1'b0;
		endcase
	end

	// ==========================================================
	// Value register pair: software writes, capture overwrites
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			vlow_reg <= CCU_BYTE_RST;
			vhigh_reg <= CCU_BYTE_RST;
		end
		// R10 R12 capture wins and overwrites unread data
		else if (cap_evt)
		begin
			vlow_reg <= timer_one_count_in[7:0];
			vhigh_reg <= timer_one_count_in[15:8];
		end
		else if (wr_en)
		begin
			if (paddr_in == CCU_VLOW_OFS)
				vlow_reg <= pwdata_in[7:0];
			if (paddr_in == CCU_VHIGH_OFS)
				vhigh_reg <= pwdata_in[7:0];
		end
	end

	// ==========================================================
	// Compare match, acted on once per entry into equality
	// R18 16-bit equality against the timer count
	assign match = (cls == CCU_COMPARE) &&
		(timer_one_count_in == {vhigh_reg, vlow_reg});
	assign match_evt = match & ~match_prev_reg;
	assign cmp_evt = match_evt;

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			match_prev_reg <= 1'b0;
		else
			match_prev_reg <= match;
	end

	// Compare output latch
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			latch_reg <= 1'b0;
		// R19 R2 off mode forces the latch low
		else if (mode == CCU_M_OFF)
			latch_reg <= 1'b0;
		// R3 pin actions on match
		else if (cmp_evt)
		begin
			case (mode)
				CCU_M_TOGGLE: latch_reg <= ~latch_reg;
				CCU_M_SET: latch_reg <= 1'b1;
				CCU_M_CLEAR: latch_reg <= 1'b0;
				default: latch_reg <= latch_reg;
			endcase
		end
	end

	// ==========================================================
	// Unit event flag: set wins over a software clear
	// R11 set by capture or compare, cleared by writing one
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			flag_reg <= 1'b0;
		else if (cap_evt || cmp_evt)
			flag_reg <= 1'b1;
		else if (wr_en && paddr_in == CCU_FLAG_OFS &&
			pwdata_in[CCU_FLAG_BIT])
			flag_reg <= 1'b0;
	end

	// ==========================================================
	// Special event trigger and deferred timer reset
	// R5 R20 conversion start at once, timer reset at next tick
	// R22 the pending reset dies if the match goes away
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			pend_reg <= 1'b0;
			adc_start_out <= 1'b0;
			timer_one_reset_out <= 1'b0;
		end
		else
		begin
			adc_start_out <= cmp_evt && (mode == CCU_M_SPECIAL);
			// R21 a separate reset line, never the overflow path
			timer_one_reset_out <= pend_reg && match &&
				timer_one_tick_in && (mode == CCU_M_SPECIAL);
			if (mode != CCU_M_SPECIAL || !match)
				pend_reg <= 1'b0;
			else if (cmp_evt)
				pend_reg <= 1'b1;
			else if (timer_one_tick_in)
				pend_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Pin steering and polarity
	logic a_n, b_n, c_n, d_n;
	logic [3:0] own_n;
	logic pol_ac;
	logic pol_bd;
	assign pol_ac = mode[1];
	assign pol_bd = mode[0];

	always_comb
	begin
		a_n = latch_reg;
		b_n = 1'b0;
		c_n = 1'b0;
		d_n = 1'b0;
		own_n = 4'h0;
		case (cls)
			// R6 R7 PWM outputs, zero polarity bit is active-high
			CCU_PWM:
			begin
				case (steer)
					CCU_S_SINGLE:
					begin
						a_n = pwm_mod_in ^ pol_ac;
						own_n = 4'h1;
					end
					CCU_S_FWD:
					begin
						a_n = ~pol_ac;
						b_n = pol_bd;
						c_n = pol_ac;
						d_n = pwm_mod_in ^ pol_bd;
						own_n = 4'hF;
					end
					CCU_S_HALF:
					begin
						a_n = pwm_mod_in ^ pol_ac;
						b_n = pwm_comp_in ^ pol_bd;
						own_n = 4'h3;
					end
					default:
					begin
						a_n = pol_ac;
						b_n = pwm_mod_in ^ pol_bd;
						c_n = ~pol_ac;
						d_n = pol_bd;
						own_n = 4'hF;
					end
				endcase
			end
			// R8 R4 only pin-acting compare modes own output A
			CCU_COMPARE:
				own_n = (mode == CCU_M_SOFT || mode == CCU_M_SPECIAL) ?
					4'h0 : 4'h1;
			default: own_n = 4'h0;
		endcase
	end

	// Registered pin outputs and duty value
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			pwm_out_a_out <= 1'b0;
			pwm_out_b_out <= 1'b0;
			pwm_out_c_out <= 1'b0;
			pwm_out_d_out <= 1'b0;
			pin_own_out <= 4'h0;
			duty_value_out <= 10'h000;
		end
		else
		begin
			pwm_out_a_out <= a_n;
			pwm_out_b_out <= b_n;
			pwm_out_c_out <= c_n;
			pwm_out_d_out <= d_n;
			pin_own_out <= own_n;
			// R9 duty low bits below the low value byte
			duty_value_out <= {vlow_reg,
				ctrl_reg[CCU_DUTY_MSB:CCU_DUTY_LSB]};
		end
	end

	// ==========================================================
	// Assertions
	off_latch_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(mode == CCU_M_OFF) |=> !latch_reg) // R19
		else $error("latch not low in off mode");
	off_free_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(cls == CCU_OFF) |=> (pin_own_out == 4'h0)) // R2
		else $error("pins owned while off");
	cap_copy_a: assert property (@(posedge clock_in) disable iff (reset_in)
		cap_evt |=> ({vhigh_reg, vlow_reg} == $past(timer_one_count_in)
		&& flag_reg)) // R10
		else $error("capture did not copy count");
	pre_clear_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(cls != CCU_CAPTURE) |=> (pre_reg == 4'h0)) // R15
		else $error("prescaler not cleared");
	cap_four_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(mode == CCU_M_CAP_4 && cap_evt) |-> (pre_reg[1:0] == 2'h3)) // R1
		else $error("fourth edge capture misplaced");
	flag_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(flag_reg && !wr_en) |=> flag_reg) // R11
		else $error("flag cleared by hardware");
	set_match_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(cmp_evt && mode == CCU_M_SET) |=> latch_reg ##1
		pwm_out_a_out) // R3
		else $error("set on match failed");
	soft_free_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(mode == CCU_M_SOFT) |=> (pin_own_out == 4'h0)) // R4
		else $error("software mode owns pin");
	trig_now_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(cmp_evt && mode == CCU_M_SPECIAL) |=> adc_start_out
		&& !timer_one_reset_out) // R20
		else $error("special trigger timing wrong");
	reset_match_a: assert property (@(posedge clock_in)
		disable iff (reset_in)
		timer_one_reset_out |-> $past(match)) // R22
		else $error("timer reset without match");
	duty_bits_a: assert property (@(posedge clock_in) disable iff (reset_in)
		##1 duty_value_out[1:0] == $past(ctrl_reg[5:4])) // R9
		else $error("duty low bits wrong");
	fwd_pins_a: assert property (@(posedge clock_in) disable iff (reset_in)
		(cls == CCU_PWM && steer == CCU_S_FWD) |=>
		(pwm_out_a_out == !$past(pol_ac)) && pin_own_out == 4'hF) // R7
		else $error("forward bridge pins wrong");
endmodule

// ==== src/ccu_pkg.sv ====
// Constants for the capture/compare/PWM control unit.
// Assumes an APB master with 32-bit data and word-aligned registers.
package ccu_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] CCU_CTRL_OFS = 8'h00;
	localparam logic [7:0] CCU_VLOW_OFS = 8'h04;
	localparam logic [7:0] CCU_VHIGH_OFS = 8'h08;
	localparam logic [7:0] CCU_FLAG_OFS = 8'h0C;
	// ==========================================================
	// Reset values
	localparam logic [7:0] CCU_CTRL_RST = 8'h00;
	localparam logic [7:0] CCU_BYTE_RST = 8'h00;
	// ==========================================================
	// Control field positions
	localparam int CCU_STEER_MSB = 7;
	localparam int CCU_STEER_LSB = 6;
	localparam int CCU_DUTY_MSB = 5;
	localparam int CCU_DUTY_LSB = 4;
	localparam int CCU_MODE_MSB = 3;
	localparam int CCU_MODE_LSB = 0;
	// Flag register bit positions
	localparam int CCU_FLAG_BIT = 0;
	localparam int CCU_ENABLE_BIT = 1;
	localparam int CCU_PIN_BIT = 2;
	localparam int CCU_LATCH_BIT = 3;
	// ==========================================================
	// Mode select codes
	localparam logic [3:0] CCU_M_OFF = 4'h0;
	localparam logic [3:0] CCU_M_TOGGLE = 4'h2;
	localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
	localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
	localparam logic [3:0] CCU_M_CAP_4 = 4'h6;
	localparam logic [3:0] CCU_M_CAP_16 = 4'h7;
	localparam logic [3:0] CCU_M_SET = 4'h8;
	localparam logic [3:0] CCU_M_CLEAR = 4'h9;
	localparam logic [3:0] CCU_M_SOFT = 4'hA;
	localparam logic [3:0] CCU_M_SPECIAL = 4'hB;
	localparam logic [1:0] CCU_M_PWM_TOP = 2'h3;
	// Steering codes
	localparam logic [1:0] CCU_S_SINGLE = 2'h0;
	localparam logic [1:0] CCU_S_FWD = 2'h1;
	localparam logic [1:0] CCU_S_HALF = 2'h2;
	localparam logic [1:0] CCU_S_REV = 2'h3;
	// Prescaler terminal counts
	localparam logic [3:0] CCU_PRE_LAST4 = 4'h3;
	localparam logic [3:0] CCU_PRE_LAST16 = 4'hF;
	// Unit operating class
	typedef enum logic [1:0] {CCU_OFF, CCU_CAPTURE, CCU_COMPARE,
		CCU_PWM} ccu_class_t;
endpackage

// ==== test/ccu_pin_src.sv ====
// External event source that drives the unit pin.
// Assumes the bench calls its tasks; the line idles low, as if pulled down.
`timescale 1ns/1ps
module ccu_pin_src
(
	// Clock
	input wire logic clock_in,
	// Pin
	output logic unit_pin_out
);
	// ==========================================================
	// Idle level
	initial unit_pin_out = 1'b0;

	// ==========================================================
	// Edges
	// edges four cycles apart
	task automatic set_level(input logic lvl);
		@(posedge clock_in);
		unit_pin_out <= lvl;
		// Held long enough for the two-stage synchroniser
		repeat (3) @(posedge clock_in);
	endtask

	// Whole pulses only, so the line always ends low
	task automatic pulse(input int n);
		repeat (n)
		begin
			set_level(1'b1);
			set_level(1'b0);
		end
	endtask
endmodule

// ==== test/ccu_top_tb.sv ====
// Self-checking bench for the capture/compare/PWM control unit.
// Assumes the unit package and the pin source model are compiled first.
`timescale 1ns/1ps
module ccu_top_tb;
	import ccu_pkg::*;
	// ==========================================================
	// Signals
	logic clock_in, reset_in, psel, pen, pwr, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] tcount;
	logic tick, trst, adc, pmod, pcomp, pin, pa, pb, pc, pd;
	logic [9:0] duty;
	logic [3:0] own;
	int fails, cmp_count, adc_cnt, trst_cnt;

	// ==========================================================
	// Instances
	ccu_top i_dut (.clock_in(clock_in), .reset_in(reset_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.timer_one_count_in(tcount), .timer_one_tick_in(tick),
		.timer_one_reset_out(trst), .adc_start_out(adc),
		.pwm_mod_in(pmod), .pwm_comp_in(pcomp), .duty_value_out(duty),
		.unit_pin_in(pin), .pwm_out_a_out(pa), .pwm_out_b_out(pb),
		.pwm_out_c_out(pc), .pwm_out_d_out(pd), .pin_own_out(own));
	ccu_pin_src i_src (.clock_in(clock_in), .unit_pin_out(pin));

	// ==========================================================
	// Clock, 25 ns period
	initial
	begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	// Pulse counters, so short pulses are never missed
	always @(posedge clock_in)
	begin
		if (adc === 1'b1)
			adc_cnt++;
		if (trst === 1'b1)
			trst_cnt++;
	end

	// ==========================================================
	// Helpers
	task automatic end_sim;
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] seen, x);
		cmp_count++;
		if (seen !== x)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, x, seen);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clock_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_in);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		// A hung slave ends the run
		if (pready !== 1'b1)
		begin
			chk("pready", {31'h0, pready}, 32'h1);
			end_sim;
		end
		else
		begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, string s);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(s, r, x);
	endtask

	task automatic setmode(input logic [7:0] m);
		wr(CCU_CTRL_OFS, 8'h00);
		wr(CCU_CTRL_OFS, m);
		wr(CCU_FLAG_OFS, 8'h01);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		rd(CCU_CTRL_OFS, 32'h0, "ctrl reset");
		rd(CCU_VLOW_OFS, 32'h0, "low reset");
		rd(CCU_VHIGH_OFS, 32'h0, "high reset");
		rd(CCU_FLAG_OFS, 32'h0, "flag reset");
		wr(CCU_FLAG_OFS, 8'h02);
		rd(CCU_FLAG_OFS, 32'h2, "enable rw");
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		wr(CCU_CTRL_OFS, 8'hFF);
		rd(CCU_CTRL_OFS, 32'hFF, "ctrl rw");
		wr(CCU_CTRL_OFS, 8'h00);
		repeat (2) @(posedge clock_in);
		chk("own off", {28'h0, own}, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_capture;
		logic [3:0] res [2] = '{4'h1, 4'h3};
		logic [3:0] pm [2] = '{CCU_M_CAP_4, CCU_M_CAP_16};
		int pn [2] = '{4, 16};
		tcount <= 16'hA5C3;
		setmode({4'h0, CCU_M_CAP_RISE});
		i_src.pulse(1);
		rd(CCU_VLOW_OFS, 32'hC3, "cap low");
		rd(CCU_VHIGH_OFS, 32'hA5, "cap high");
		rd(CCU_FLAG_OFS, 32'h1, "cap flag");
		tcount <= 16'h0F1E;
		i_src.pulse(1);
		rd(CCU_VLOW_OFS, 32'h1E, "new low");
		rd(CCU_VHIGH_OFS, 32'h0F, "new high");
		wr(CCU_FLAG_OFS, 8'h01);
		rd(CCU_FLAG_OFS, 32'h0, "flag clear");
		setmode({4'h0, CCU_M_CAP_FALL});
		i_src.set_level(1'b1);
		rd(CCU_FLAG_OFS, 32'h4, "rise ignored");
		i_src.set_level(1'b0);
		rd(CCU_FLAG_OFS, 32'h1, "fall capture");
		for (int i = 0; i < 2; i++)
		begin
			setmode({4'h0, pm[i]});
			i_src.pulse(pn[i] - 1);
			rd(CCU_FLAG_OFS, 32'h0, "prescale early");
			i_src.pulse(1);
			rd(CCU_FLAG_OFS, 32'h1, "prescale hit");
			setmode({4'h0, res[i]});
			i_src.pulse(1);
			rd(CCU_FLAG_OFS, 32'h0, "reserved quiet");
		end
		$display("test capture done");
	endtask

	// Near miss on the high byte, then a full match
	task automatic match(input logic l);
		logic [15:0] v;
		v = 16'h1234;
		tcount <= v ^ 16'h0100;
		repeat (3) @(posedge clock_in);
		rd(CCU_FLAG_OFS, {28'h0, ~l, 3'h0}, "near miss");
		tcount <= v;
		repeat (3) @(posedge clock_in);
		chk("cmp pin", {31'h0, pa}, {31'h0, l});
		chk("cmp own", {28'h0, own}, 32'h1);
		rd(CCU_FLAG_OFS, {28'h0, l, 3'h1}, "cmp flag");
		tcount <= 16'h0000;
		wr(CCU_FLAG_OFS, 8'h01);
	endtask

	task automatic t_compare;
		tcount <= 16'h0000;
		wr(CCU_VLOW_OFS, 8'h34);
		wr(CCU_VHIGH_OFS, 8'h12);
		// Steering set but must be ignored here
		setmode({CCU_S_REV, 2'h0, CCU_M_SET});
		match(1'b1);
		wr(CCU_CTRL_OFS, {4'h0, CCU_M_CLEAR});
		match(1'b0);
		wr(CCU_CTRL_OFS, {4'h0, CCU_M_TOGGLE});
		match(1'b1);
		match(1'b0);
		match(1'b1);
		wr(CCU_CTRL_OFS, 8'h00);
		repeat (2) @(posedge clock_in);
		chk("off own", {28'h0, own}, 32'h0);
		rd(CCU_FLAG_OFS, 32'h0, "off latch");
		$display("test compare done");
	endtask

	task automatic t_special;
		wr(CCU_CTRL_OFS, {4'h0, CCU_M_SOFT});
		wr(CCU_FLAG_OFS, 8'h01);
		tcount <= 16'h1234;
		repeat (3) @(posedge clock_in);
		chk("soft own", {28'h0, own}, 32'h0);
		rd(CCU_FLAG_OFS, 32'h1, "soft flag");
		tcount <= 16'h0000;
		wr(CCU_CTRL_OFS, {4'h0, CCU_M_SPECIAL});
		wr(CCU_FLAG_OFS, 8'h01);
		tcount <= 16'h1234;
		repeat (6) @(posedge clock_in);
		chk("trigger", adc_cnt, 32'h1);
		chk("early reset", trst_cnt, 32'h0);
		chk("special own", {28'h0, own}, 32'h0);
		tick <= 1'b1;
		@(posedge clock_in);
		tick <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk("timer reset", trst_cnt, 32'h1);
		rd(CCU_FLAG_OFS, 32'h1, "special flag");
		tcount <= 16'h0000;
		repeat (3) @(posedge clock_in);
		tcount <= 16'h1234;
		repeat (3) @(posedge clock_in);
		// Match removed before the tick
		wr(CCU_VLOW_OFS, 8'h35);
		tick <= 1'b1;
		@(posedge clock_in);
		tick <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk("second trigger", adc_cnt, 32'h2);
		chk("cancelled", trst_cnt, 32'h1);
		$display("test special done");
	endtask

	task automatic t_pwm;
		logic [3:0] x, o;
		logic ac, bd, m;
		wr(CCU_VLOW_OFS, 8'hA7);
		for (int k = 0; k < 32; k++)
		begin
			m = k[4];
			ac = k[1];
			bd = k[0];
			pmod <= m;
			pcomp <= ~m;
			wr(CCU_CTRL_OFS, {k[3:2], 2'h2, CCU_M_PWM_TOP, k[1:0]});
			repeat (3) @(posedge clock_in);
			// Expected levels, ordered D C B A
			case (k[3:2])
				2'h0: {o, x} = {4'h1, bd, ac, bd, m ^ ac};
				2'h1: {o, x} = {4'hF, m ^ bd, ac, bd, ~ac};
				2'h2: {o, x} = {4'h3, bd, ac, ~m ^ bd, m ^ ac};
				default: {o, x} = {4'hF, bd, ~ac, m ^ bd, ac};
			endcase
			chk("pwm own", {28'h0, own}, {28'h0, o});
			chk("pwm pins", {28'h0, {pd, pc, pb, pa} & o},
				{28'h0, x & o});
			chk("duty", {22'h0, duty}, {22'h0, 8'hA7, 2'h2});
		end
		wr(CCU_CTRL_OFS, 8'h00);
		repeat (2) @(posedge clock_in);
		chk("pwm off", {28'h0, own}, 32'h0);
		$display("test pwm done");
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		reset_in = 1'b1;
		{psel, pen, pwr, tick, pmod} = 5'h00;
		// Complement line idles opposite the modulated line
		pcomp = ~pmod;
		paddr = 8'h00;
		pwdata = 32'h0;
		tcount = 16'h0000;
		fails = 0;
		cmp_count = 0;
		adc_cnt = 0;
		trst_cnt = 0;
		repeat (8) @(posedge clock_in);
		reset_in <= 1'b0;
		t_reset;
		t_capture;
		t_compare;
		t_special;
		t_pwm;
		end_sim;
	end
endmodule
